// ===== logic/axd_top.sv
`timescale 1ns/1ns
module axd_top import axd_pkg::*; #(
   parameter int unsigned CYCLE_CLKS = CTRL_CYCLE_CLKS
) (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [3:0] WB_SEL_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic signed [15:0] POS_LAG_IN,
   input wire logic signed [15:0] POS_CTRL_IN,
   input wire logic signed [15:0] PRESS_SET_IN,
   input wire logic signed [15:0] PRESS_ACT_IN,
   input wire logic signed [15:0] SPEED_IN,
   output logic [8:0] LOOP_GAIN_OUT,
   output logic signed [15:0] DRIFT_OUT,
   output logic signed [15:0] PRESS_CTRL_OUT,
   output logic signed [15:0] MODULE_OUT,
   output logic signed [15:0] BUS_SIG1_OUT,
   output logic signed [15:0] BUS_SIG2_OUT
);
   generate
      if (CYCLE_CLKS < 2) begin : g_bad_cycle
         $error("CYCLE_CLKS must be at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [6:0] ctrl;
      logic [8:0] base_a;
      logic [8:0] base_b;
      logic [8:0] afc_a;
      logic [8:0] afc_b;
      logic [10:0] dc_time;
      logic [10:0] dc_act;
      logic [9:0] dc_deact;
      logic [8:0] dc_clamp;
      logic [9:0] lin_t1;
      logic [9:0] lin_t2;
      logic [2:0] sel1;
      logic [2:0] sel2;
      logic [13:0] p_ulim;
      logic signed [15:0] p_llim;
      logic [31:0] tick_cnt;
      logic [10:0] dc_cnt;
      logic [9:0] lin1_cnt;
      logic [9:0] lin2_cnt;
      logic signed [25:0] dc_static;
      logic signed [25:0] dc_dyn;
      logic signed [25:0] p_int;
      logic signed [15:0] lin_f1;
      logic signed [15:0] lin_f2;
      logic near;
      logic frozen;
      logic [8:0] gain;
      logic signed [15:0] drift;
      logic signed [15:0] p_out;
      logic signed [15:0] mod_out;
      logic signed [15:0] bus1;
      logic signed [15:0] bus2;
      logic ack;
      logic [31:0] dat;
   } axd_state_s;

   axd_state_s s_ff;
   axd_state_s nxt_s;

   function automatic logic signed [25:0] clip(
      input logic signed [25:0] v,
      input logic signed [25:0] lo,
      input logic signed [25:0] hi);
      logic signed [25:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   function automatic logic signed [15:0] sat16(
      input logic signed [25:0] v);
      logic signed [25:0] lim;
      lim = signed'(26'(SIG_LIM));
      return 16'(clip(v, -lim, lim));
   endfunction

   function automatic logic [15:0] wmerge(
      input logic [15:0] old,
      input logic [31:0] d,
      input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Writes above a range are pinned to its top so the logic never sees
   // a value it was not sized for
   function automatic logic [15:0] umax(
      input logic [15:0] v,
      input logic [15:0] mx);
      return (v > mx) ? mx : v;
   endfunction

   function automatic logic signed [15:0] pick(
      input logic [2:0] sel,
      input logic signed [15:0] lag,
      input logic signed [15:0] pos,
      input logic signed [15:0] pset,
      input logic signed [15:0] perr,
      input logic signed [15:0] pctl,
      input logic signed [15:0] modv,
      input logic signed [15:0] spd);
      logic signed [15:0] r;
      r = 16'sh0000;
      unique case (axd_sel_e'(sel))
         SEL_NONE: r = 16'sh0000;
         SEL_LAG: r = lag;
         SEL_POS_CTRL: r = pos;
         SEL_P_SET: r = pset;
         SEL_P_ERR: r = perr;
         SEL_P_CTRL: r = pctl;
         SEL_MODULE: r = modv;
         SEL_SPEED: r = spd;
      endcase
      return r;
   endfunction

   logic tick;
   logic req;
   logic wr;
   logic signed [16:0] cs17;
   logic [16:0] mag;
   logic dc_on;
   logic dc_step;
   logic lin_on;
   logic lin1_step;
   logic lin2_step;
   logic signed [25:0] dc_lim;
   logic signed [25:0] p_err;
   logic signed [15:0] p_err16;
   logic signed [15:0] pos_sum;
   logic signed [15:0] lead;
   logic signed [15:0] lin_out;
   logic signed [15:0] p_raw;
   logic signed [15:0] u_val;
   logic [15:0] wval;
   logic [15:0] wsig;

   always_comb begin
      nxt_s = s_ff;
      tick = (s_ff.tick_cnt == CYCLE_CLKS - 1);
      req = WB_CYC_IN && WB_STB_IN && !s_ff.ack;
      wr = req && WB_WE_IN;
      cs17 = 17'(POS_CTRL_IN);
      mag = 17'((cs17 < 0) ? -cs17 : cs17);
      wval = 16'h0000;
      wsig = 16'h0000;

      nxt_s.tick_cnt = tick ? 32'h0000_0000 : s_ff.tick_cnt + 32'h0000_0001;

      nxt_s.gain = s_ff.ctrl[CTRL_ACCEL_FB] ?
         ((POS_CTRL_IN >= 0) ? s_ff.afc_a : s_ff.afc_b) :
         ((POS_CTRL_IN >= 0) ? s_ff.base_a : s_ff.base_b);

      // Drift compensation, stepped once per integrator time
      dc_on = s_ff.ctrl[CTRL_DRIFT_EN] && (s_ff.dc_act != 11'h000);
      nxt_s.near = dc_on && (mag < 17'(s_ff.dc_act));
      nxt_s.frozen = mag < 17'(s_ff.dc_deact);
      dc_step = tick && (s_ff.dc_cnt >= s_ff.dc_time);
      if (tick) begin
         nxt_s.dc_cnt = dc_step ? 11'h000 : s_ff.dc_cnt + 11'h001;
      end
      dc_lim = signed'(26'(s_ff.dc_clamp)) <<< INT_FRAC;
      if (!dc_on) begin
         nxt_s.dc_static = 26'sh0;
         nxt_s.dc_dyn = 26'sh0;
      end else begin
         // The integrator steps by the raw controller output, so the
         // slope tracks the error and a zero time gives the fastest rate
         if (dc_step && s_ff.near && !s_ff.frozen &&
               !s_ff.ctrl[CTRL_DRIFT_HOLD]) begin
            nxt_s.dc_static = clip(s_ff.dc_static + 26'(cs17),
               -dc_lim, dc_lim);
         end
         // External-force part follows the load and is dropped when
         // the axis leaves the target area
         if (!s_ff.ctrl[CTRL_FINE_POS] || !s_ff.near) begin
            nxt_s.dc_dyn = 26'sh0;
         end else if (dc_step && !s_ff.frozen) begin
            nxt_s.dc_dyn = clip(s_ff.dc_dyn + 26'(cs17), -dc_lim, dc_lim);
         end
      end
      nxt_s.drift = 16'(clip((s_ff.dc_static + s_ff.dc_dyn) >>> INT_FRAC,
         -signed'(26'(s_ff.dc_clamp)), signed'(26'(s_ff.dc_clamp))));

      pos_sum = sat16(26'(POS_CTRL_IN) + 26'(s_ff.drift));

      // Load linearizer: lag stage on T1, lead, then smoothing on T2
      lin_on = s_ff.ctrl[CTRL_LIN_EN] && s_ff.ctrl[CTRL_NC_MODE];
      lin1_step = tick && (s_ff.lin1_cnt >= s_ff.lin_t1);
      lin2_step = tick && (s_ff.lin2_cnt >= s_ff.lin_t2);
      if (tick) begin
         nxt_s.lin1_cnt = lin1_step ? 10'h000 : s_ff.lin1_cnt + 10'h001;
         nxt_s.lin2_cnt = lin2_step ? 10'h000 : s_ff.lin2_cnt + 10'h001;
      end
      lead = sat16(26'(pos_sum) + ((26'(pos_sum) - 26'(s_ff.lin_f1)) >>> 1));
      if (!lin_on) begin
         // Filters track the input so switching on causes no jump
         nxt_s.lin_f1 = pos_sum;
         nxt_s.lin_f2 = pos_sum;
      end else begin
         if (lin1_step) begin
            nxt_s.lin_f1 = sat16(26'(s_ff.lin_f1) +
               ((26'(pos_sum) - 26'(s_ff.lin_f1)) >>> 2));
         end
         if (lin2_step) begin
            nxt_s.lin_f2 = sat16(26'(s_ff.lin_f2) +
               ((26'(lead) - 26'(s_ff.lin_f2)) >>> 2));
         end
      end
      lin_out = lin_on ? s_ff.lin_f2 : pos_sum;

      // Pressure controller with limited integral part
      p_err = 26'(PRESS_SET_IN) - 26'(PRESS_ACT_IN);
      p_err16 = sat16(p_err);
      if (!s_ff.ctrl[CTRL_PRESS_EN]) begin
         nxt_s.p_int = 26'sh0;
      end else if (tick) begin
         nxt_s.p_int = clip(s_ff.p_int + p_err,
            signed'(26'(s_ff.p_llim)) <<< INT_FRAC,
            signed'(26'(s_ff.p_ulim)) <<< INT_FRAC);
      end
      p_raw = sat16(p_err + (s_ff.p_int >>> INT_FRAC));
      nxt_s.p_out = (p_raw < s_ff.p_llim) ? s_ff.p_llim : p_raw;
      // Minimum selection hands over smoothly as P plus integral drops
      u_val = (s_ff.ctrl[CTRL_PRESS_EN] && (s_ff.p_out < lin_out)) ?
         s_ff.p_out : lin_out;
      nxt_s.mod_out = u_val;

      nxt_s.bus1 = pick(s_ff.sel1, POS_LAG_IN, POS_CTRL_IN, PRESS_SET_IN,
         p_err16, s_ff.p_out, s_ff.mod_out, SPEED_IN);
      nxt_s.bus2 = pick(s_ff.sel2, POS_LAG_IN, POS_CTRL_IN, PRESS_SET_IN,
         p_err16, s_ff.p_out, s_ff.mod_out, SPEED_IN);

      // Wishbone slave: one wait-free answer, ack drops after one cycle
      nxt_s.ack = req;
      nxt_s.dat = 32'h0000_0000;
      if (wr) begin
         unique case (WB_ADR_IN[7:2])
            ADR_CTRL: begin
               wval = wmerge(16'(s_ff.ctrl), WB_DAT_IN, WB_SEL_IN);
               nxt_s.ctrl = wval[6:0];
            end
            ADR_BASE_GAIN_A, ADR_BASE_GAIN_B, ADR_AFC_GAIN_A,
            ADR_AFC_GAIN_B: begin
               wval = wmerge(16'h0000, WB_DAT_IN, WB_SEL_IN);
               wval = (wval < GAIN_MIN) ? GAIN_MIN : umax(wval, GAIN_MAX);
               if (WB_ADR_IN[7:2] == ADR_BASE_GAIN_A) begin
                  nxt_s.base_a = wval[8:0];
               end else if (WB_ADR_IN[7:2] == ADR_BASE_GAIN_B) begin
                  nxt_s.base_b = wval[8:0];
               end else if (WB_ADR_IN[7:2] == ADR_AFC_GAIN_A) begin
                  nxt_s.afc_a = wval[8:0];
               end else begin
                  nxt_s.afc_b = wval[8:0];
               end
            end
            ADR_DC_TIME: begin
               wval = wmerge(16'(s_ff.dc_time), WB_DAT_IN, WB_SEL_IN);
               nxt_s.dc_time = 11'(umax(wval, DC_TIME_MAX));
            end
            ADR_DC_ACT: begin
               wval = wmerge(16'(s_ff.dc_act), WB_DAT_IN, WB_SEL_IN);
               nxt_s.dc_act = 11'(umax(wval, DC_ACT_MAX));
            end
            ADR_DC_DEACT: begin
               wval = wmerge(16'(s_ff.dc_deact), WB_DAT_IN, WB_SEL_IN);
               nxt_s.dc_deact = 10'(umax(wval, DC_DEACT_MAX));
            end
            ADR_DC_CLAMP: begin
               wval = wmerge(16'(s_ff.dc_clamp), WB_DAT_IN, WB_SEL_IN);
               nxt_s.dc_clamp = 9'(umax(wval, DC_CLAMP_MAX));
            end
            ADR_LIN_T1: begin
               wval = wmerge(16'(s_ff.lin_t1), WB_DAT_IN, WB_SEL_IN);
               nxt_s.lin_t1 = 10'(umax(wval, LIN_T_MAX));
            end
            ADR_LIN_T2: begin
               wval = wmerge(16'(s_ff.lin_t2), WB_DAT_IN, WB_SEL_IN);
               nxt_s.lin_t2 = 10'(umax(wval, LIN_T_MAX));
            end
            ADR_SELECT: begin
               wval = wmerge({9'h000, s_ff.sel2, 1'b0, s_ff.sel1},
                  WB_DAT_IN, WB_SEL_IN);
               nxt_s.sel1 = wval[2:0];
               nxt_s.sel2 = wval[SEL2_POS +: 3];
            end
            ADR_P_ULIM: begin
               wval = wmerge(16'(s_ff.p_ulim), WB_DAT_IN, WB_SEL_IN);
               nxt_s.p_ulim = 14'(umax(wval, P_LIM_MAX));
            end
            ADR_P_LLIM: begin
               wsig = wmerge(s_ff.p_llim, WB_DAT_IN, WB_SEL_IN);
               if (signed'(wsig) > 16'sh0000) begin
                  nxt_s.p_llim = 16'sh0000;
               end else if (signed'(wsig) < P_LLIM_MIN) begin
                  nxt_s.p_llim = P_LLIM_MIN;
               end else begin
                  nxt_s.p_llim = signed'(wsig);
               end
            end
            default: begin
               wval = 16'h0000;
            end
         endcase
      end else if (req) begin
         unique case (WB_ADR_IN[7:2])
            ADR_CTRL: nxt_s.dat = 32'(s_ff.ctrl);
            ADR_BASE_GAIN_A: nxt_s.dat = 32'(s_ff.base_a);
            ADR_BASE_GAIN_B: nxt_s.dat = 32'(s_ff.base_b);
            ADR_AFC_GAIN_A: nxt_s.dat = 32'(s_ff.afc_a);
            ADR_AFC_GAIN_B: nxt_s.dat = 32'(s_ff.afc_b);
            ADR_DC_TIME: nxt_s.dat = 32'(s_ff.dc_time);
            ADR_DC_ACT: nxt_s.dat = 32'(s_ff.dc_act);
            ADR_DC_DEACT: nxt_s.dat = 32'(s_ff.dc_deact);
            ADR_DC_CLAMP: nxt_s.dat = 32'(s_ff.dc_clamp);
            ADR_LIN_T1: nxt_s.dat = 32'(s_ff.lin_t1);
            ADR_LIN_T2: nxt_s.dat = 32'(s_ff.lin_t2);
            ADR_SELECT: nxt_s.dat = {25'h0, s_ff.sel2, 1'b0, s_ff.sel1};
            ADR_P_ULIM: nxt_s.dat = 32'(s_ff.p_ulim);
            ADR_P_LLIM: nxt_s.dat = {16'h0000, s_ff.p_llim};
            ADR_STATUS: nxt_s.dat = {14'h0000, s_ff.frozen, s_ff.near,
               s_ff.drift};
            ADR_BUSDATA: nxt_s.dat = {s_ff.bus2, s_ff.bus1};
            default: nxt_s.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         s_ff <= '0;
         s_ff.base_a <= RST_GAIN;
         s_ff.base_b <= RST_GAIN;
         s_ff.afc_a <= RST_GAIN;
         s_ff.afc_b <= RST_GAIN;
         s_ff.gain <= RST_GAIN;
         s_ff.dc_time <= RST_DC_TIME;
         s_ff.p_ulim <= RST_P_ULIM;
         s_ff.p_llim <= RST_P_LLIM;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign WB_DAT_OUT = s_ff.dat;
   assign WB_ACK_OUT = s_ff.ack;
   assign LOOP_GAIN_OUT = s_ff.gain;
   assign DRIFT_OUT = s_ff.drift;
   assign PRESS_CTRL_OUT = s_ff.p_out;
   assign MODULE_OUT = s_ff.mod_out;
   assign BUS_SIG1_OUT = s_ff.bus1;
   assign BUS_SIG2_OUT = s_ff.bus2;
endmodule

// ===== logic/axd_pkg.sv
package axd_pkg;
   localparam int unsigned CLK_FREQ_MHZ = 125;
   localparam int unsigned CTRL_CYCLE_US = 1000;
   localparam int unsigned CTRL_CYCLE_CLKS = CTRL_CYCLE_US * CLK_FREQ_MHZ;

   localparam logic [5:0] ADR_CTRL = 6'h00;
   localparam logic [5:0] ADR_BASE_GAIN_A = 6'h01;
   localparam logic [5:0] ADR_BASE_GAIN_B = 6'h02;
   localparam logic [5:0] ADR_AFC_GAIN_A = 6'h03;
   localparam logic [5:0] ADR_AFC_GAIN_B = 6'h04;
   localparam logic [5:0] ADR_DC_TIME = 6'h05;
   localparam logic [5:0] ADR_DC_ACT = 6'h06;
   localparam logic [5:0] ADR_DC_DEACT = 6'h07;
   localparam logic [5:0] ADR_DC_CLAMP = 6'h08;
   localparam logic [5:0] ADR_LIN_T1 = 6'h09;
   localparam logic [5:0] ADR_LIN_T2 = 6'h0a;
   localparam logic [5:0] ADR_SELECT = 6'h0b;
   localparam logic [5:0] ADR_P_ULIM = 6'h0c;
   localparam logic [5:0] ADR_P_LLIM = 6'h0d;
   localparam logic [5:0] ADR_STATUS = 6'h0e;
   localparam logic [5:0] ADR_BUSDATA = 6'h0f;

   localparam int unsigned CTRL_ACCEL_FB = 0;
   localparam int unsigned CTRL_DRIFT_EN = 1;
   localparam int unsigned CTRL_DRIFT_HOLD = 2;
   localparam int unsigned CTRL_FINE_POS = 3;
   localparam int unsigned CTRL_LIN_EN = 4;
   localparam int unsigned CTRL_NC_MODE = 5;
   localparam int unsigned CTRL_PRESS_EN = 6;
   localparam int unsigned SEL2_POS = 4;
   localparam int unsigned STAT_NEAR = 16;
   localparam int unsigned STAT_FROZEN = 17;

   localparam logic [15:0] GAIN_MIN = 16'h0001;
   localparam logic [15:0] GAIN_MAX = 16'h0190;
   localparam logic [15:0] DC_TIME_MAX = 16'h07d0;
   localparam logic [15:0] DC_ACT_MAX = 16'h07d0;
   localparam logic [15:0] DC_DEACT_MAX = 16'h03e8;
   localparam logic [15:0] DC_CLAMP_MAX = 16'h01f4;
   localparam logic [15:0] LIN_T_MAX = 16'h03e8;
   localparam logic [15:0] P_LIM_MAX = 16'h2710;
   localparam logic signed [15:0] P_LLIM_MIN = 16'shd8f0;
   localparam logic [13:0] SIG_LIM = 14'h2710;
   localparam int unsigned INT_FRAC = 8;

   localparam logic [8:0] RST_GAIN = 9'h00a;
   localparam logic [10:0] RST_DC_TIME = 11'h5dc;
   localparam logic [13:0] RST_P_ULIM = 14'h2710;
   localparam logic signed [15:0] RST_P_LLIM = 16'shd8f0;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0, SEL_LAG = 3'h1, SEL_POS_CTRL = 3'h2,
      SEL_P_SET = 3'h3, SEL_P_ERR = 3'h4, SEL_P_CTRL = 3'h5,
      SEL_MODULE = 3'h6, SEL_SPEED = 3'h7
   } axd_sel_e;
endpackage

// ===== test/axd_top_checker.sv
`timescale 1ns/1ns
module axd_top_checker import axd_pkg::*; (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic WB_ACK_OUT,
   input wire logic signed [15:0] POS_LAG_IN,
   input wire logic [8:0] LOOP_GAIN_OUT,
   input wire logic signed [15:0] DRIFT_OUT,
   input wire logic signed [15:0] MODULE_OUT,
   input wire logic signed [15:0] BUS_SIG1_OUT
);
   logic req;
   logic wr_take;
   logic [7:0] ctrl_ff;
   logic [2:0] sel1_ff;
   assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
   assign wr_take = req && WB_WE_IN && WB_SEL_IN[0];
   // Shadow of control and select bytes, so drift and routing can be
   // judged from bus traffic alone
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_ff <= 8'h00;
         sel1_ff <= 3'h0;
      end else if (wr_take) begin
         if (WB_ADR_IN[7:2] == ADR_CTRL) begin
            ctrl_ff <= WB_DAT_IN[7:0];
         end
         if (WB_ADR_IN[7:2] == ADR_SELECT) begin
            sel1_ff <= WB_DAT_IN[2:0];
         end
      end
   end
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (RST_IN);
   a_ack_due: assert property (req |=> WB_ACK_OUT)
      else $error("no ack after request");
   a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held too long");
   a_rdata_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
      else $error("read data outside ack");
   a_gain_range: assert property (
      LOOP_GAIN_OUT >= 9'h001 && LOOP_GAIN_OUT <= 9'h190)
      else $error("loop gain out of range");
   a_drift_clamp: assert property (
      DRIFT_OUT <= 16'sh01f4 && DRIFT_OUT >= 16'shfe0c)
      else $error("drift beyond clamp");
   a_out_sat: assert property (
      MODULE_OUT <= 16'sh2710 && MODULE_OUT >= 16'shd8f0)
      else $error("module output not saturated");
   a_drift_off: assert property (
      (!ctrl_ff[CTRL_DRIFT_EN]) [*3] |-> DRIFT_OUT == 16'sh0000)
      else $error("drift acts while disabled");
   a_lag_route: assert property (
      sel1_ff == SEL_LAG && $past(sel1_ff) == SEL_LAG
      |-> BUS_SIG1_OUT == $past(POS_LAG_IN))
      else $error("bus word one does not carry lag");
endmodule

bind axd_top axd_top_checker i_axd_top_checker (
   .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_DAT_IN(WB_DAT_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_OUT(WB_DAT_OUT),
   .WB_ACK_OUT(WB_ACK_OUT), .POS_LAG_IN(POS_LAG_IN),
   .LOOP_GAIN_OUT(LOOP_GAIN_OUT), .DRIFT_OUT(DRIFT_OUT),
   .MODULE_OUT(MODULE_OUT), .BUS_SIG1_OUT(BUS_SIG1_OUT));

// ===== test/axd_host.sv
`timescale 1ns/1ns
// Fieldbus-side master: sets control bits and tunes the block
module axd_host (
   input wire logic clk_in,
   input wire logic [31:0] dat_in,
   input wire logic ack_in,
   output logic cyc_out,
   output logic stb_out,
   output logic we_out,
   output logic [7:0] adr_out,
   output logic [31:0] dat_out,
   output logic [3:0] sel_out
);
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      adr_out = 8'h00;
      dat_out = 32'h0000_0000;
      sel_out = 4'h0;
   end
   // No wait limit here: a silent slave is cut off by the bench watchdog
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      dat_out <= d;
      sel_out <= 4'hf;
      do begin
         @(posedge clk_in);
      end while (ack_in !== 1'b1);
      r = dat_in;
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
      // Stale address and data would hide a slave that ignores strobe
      adr_out <= ~a;
      dat_out <= ~d;
   endtask
endmodule

// ===== test/axd_top_tb.sv
`timescale 1ns/1ns
module axd_top_tb import axd_pkg::*; #(
   parameter int unsigned CYC = 8
);
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [8:0] gain;
   logic signed [15:0] lag = 16'sh0000, pos = 16'sh0000, pset = 16'sh0000;
   logic signed [15:0] pact = 16'sh0000, spd = 16'sh0000;
   logic signed [15:0] drift, pout, mout, bs1, bs2, hold_v;
   int n_fail = 0;
   int cmp_count = 0;

   always #4 mclk = ~mclk;

   axd_top #(.CYCLE_CLKS(CYC)) i_axd_top (
      .MCLK_IN(mclk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(sel),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .POS_LAG_IN(lag),
      .POS_CTRL_IN(pos), .PRESS_SET_IN(pset), .PRESS_ACT_IN(pact),
      .SPEED_IN(spd), .LOOP_GAIN_OUT(gain), .DRIFT_OUT(drift),
      .PRESS_CTRL_OUT(pout), .MODULE_OUT(mout), .BUS_SIG1_OUT(bs1),
      .BUS_SIG2_OUT(bs2));
   axd_host i_axd_host (
      .clk_in(mclk), .dat_in(rdat), .ack_in(ack), .cyc_out(cyc),
      .stb_out(stb), .we_out(we), .adr_out(adr), .dat_out(wdat),
      .sel_out(sel));

   task automatic print_verdict();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pause(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [31:0] r;
      i_axd_host.xfer(1'b1, {a, 2'b00}, {16'h0000, d}, r);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] r;
      i_axd_host.xfer(1'b0, {a, 2'b00}, 32'h0000_0000, r);
      chk(r, e);
   endtask
   task automatic lim(input logic [5:0] a, input logic [15:0] d,
         input logic [15:0] e);
      wr(a, d);
      rdc(a, {16'h0000, e});
   endtask
   task automatic drive(input logic signed [15:0] p);
      @(posedge mclk);
      pos <= p;
   endtask
   // Drift must not move for 200 cycles; shorter spans can hide a slow
   // integrator, and the first three cycles let a step in flight settle
   task automatic steady();
      pause(3);
      hold_v = drift;
      pause(200);
      chk(drift, hold_v);
   endtask

   task automatic t_regs();
      chk(gain, 32'h0000_000a);
      rdc(ADR_DC_TIME, 32'h0000_05dc);
      rdc(ADR_P_LLIM, 32'h0000_d8f0);
      wr(6'h20, 16'h1234);
      rdc(6'h20, 32'h0000_0000);
      lim(ADR_BASE_GAIN_A, 16'h01f4, 16'h0190);
      lim(ADR_AFC_GAIN_A, 16'h0000, 16'h0001);
      lim(ADR_DC_TIME, 16'h0bb8, 16'h07d0);
      lim(ADR_DC_ACT, 16'h09c4, 16'h07d0);
      lim(ADR_DC_DEACT, 16'h07d0, 16'h03e8);
      lim(ADR_DC_CLAMP, 16'h0258, 16'h01f4);
      lim(ADR_LIN_T1, 16'h07d0, 16'h03e8);
      lim(ADR_P_ULIM, 16'h4e20, 16'h2710);
      lim(ADR_P_LLIM, 16'h0005, 16'h0000);
   endtask
   task automatic t_gain();
      wr(ADR_BASE_GAIN_A, 16'h0014);
      wr(ADR_BASE_GAIN_B, 16'h001e);
      wr(ADR_AFC_GAIN_A, 16'h0032);
      wr(ADR_AFC_GAIN_B, 16'h003c);
      drive(16'sh0064);
      wr(ADR_CTRL, 16'h0001);
      pause(3);
      chk(gain, 32'h0000_0032);
      drive(16'shff9c);
      pause(3);
      chk(gain, 32'h0000_003c);
      wr(ADR_CTRL, 16'h0000);
      pause(3);
      chk(gain, 32'h0000_001e);
   endtask
   task automatic t_bus();
      logic [15:0] e[8];
      e = '{16'h0000, 16'h0123, 16'h0234, 16'h0100, 16'h00c0, 16'h00c0,
         16'h0234, 16'h0456};
      @(posedge mclk);
      lag <= 16'sh0123;
      pos <= 16'sh0234;
      pset <= 16'sh0100;
      pact <= 16'sh0040;
      spd <= 16'sh0456;
      for (int i = 0; i < 8; i++) begin
         wr(ADR_SELECT, 16'(i * 17));
         pause(3);
         chk(bs1, {16'h0000, e[i]});
         chk(bs2, {16'h0000, e[i]});
      end
      rdc(ADR_BUSDATA, 32'h0456_0456);
      chk(mout, 32'h0000_0234);
   endtask
   task automatic t_press();
      @(posedge mclk);
      pset <= 16'sh0064;
      pact <= 16'sh01f4;
      wr(ADR_CTRL, 16'h0040);
      pause(40);
      chk(pout, 32'h0000_0000);
      chk(mout, 32'h0000_0000);
      wr(ADR_P_LLIM, 16'hd8f0);
      pause(40);
      chk({31'h0, pout[15]}, 32'h0000_0001);
   endtask
   task automatic t_drift();
      wr(ADR_DC_ACT, 16'h012c);
      wr(ADR_DC_CLAMP, 16'h012c);
      wr(ADR_DC_DEACT, 16'h0032);
      wr(ADR_DC_TIME, 16'h0000);
      drive(16'sh0064);
      wr(ADR_CTRL, 16'h0002);
      pause(400);
      chk({31'h0, drift > 16'sh0000}, 32'h0000_0001);
      wr(ADR_CTRL, 16'h0006);
      steady();
      wr(ADR_CTRL, 16'h0002);
      drive(16'sh0014);
      steady();
      drive(16'sh0190);
      steady();
      wr(ADR_CTRL, 16'h0000);
      pause(3);
      chk(drift, 32'h0000_0000);
      wr(ADR_CTRL, 16'h0008);
      pause(100);
      chk(drift, 32'h0000_0000);
      wr(ADR_DC_ACT, 16'h0000);
      drive(16'sh0064);
      wr(ADR_CTRL, 16'h0002);
      pause(100);
      chk(drift, 32'h0000_0000);
   endtask
   // Long second time constant keeps the filter still, so the output lags
   task automatic t_lin();
      wr(ADR_LIN_T2, 16'h03e8);
      wr(ADR_CTRL, 16'h0030);
      drive(16'sh00c8);
      pause(10);
      chk({31'h0, mout < 16'sh00c8}, 32'h0000_0001);
      wr(ADR_CTRL, 16'h0010);
      pause(3);
      chk(mout, 32'h0000_00c8);
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      t_regs();
      t_gain();
      t_bus();
      t_press();
      t_drift();
      t_lin();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      print_verdict();
   end
endmodule
